// file: rtl/bss_exec.sv
// Execution unit for compare-immediate, skips, flag branches, I/O bit ops
// and shifts
//
// How it works
// - Compare with constant, flags only, one cycle
// - Skip on working register bit value
// - Skip on low I/O register bit
// - Flag branch loads PC plus k plus one
// - Carry, zero, negative branches test one flag
// - Signed branches test N xor V
// - Half-carry branches on H set or clear
// - Transfer bit branches on T
// - Overflow branches on V
// - Interrupt enable branches on I
// - Set or clear one I/O bit, two cycles
// - Logical left shift, zero into bit 0
// - Logical right shift, zero into bit 7
// - Rotate left through carry
// - Rotate right through carry
// - Arithmetic right shift keeps bit 7
// - Swap nibbles, no flags changed
// - I/O bit ops reach addresses 0x00 to 0x1F
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module bss_exec
   import bss_pkg::*;
#(
   parameter int PC_W = 13                      // Program counter width
) (
   input  wire logic            REF_CLK,        // Core clock, 100 MHz
   input  wire logic            RESET,          // Async reset, high
   input  wire logic            INSTR_VALID,    // Instruction word present
   input  wire logic [15:0]     INSTR,          // Instruction at PC
   input  wire logic [15:0]     NEXT_INSTR,     // Word after it
   output logic                 BUSY,           // Stall, hold instruction
   output logic [PC_W-1:0]      PC,             // Program counter
   output logic [4:0]           RF_RADDR,       // Register read address
   input  wire logic [7:0]      RF_RDATA,       // Register read data
   output logic                 RF_WE,          // Register write strobe
   output logic [4:0]           RF_WADDR,       // Register write address
   output logic [7:0]           RF_WDATA,       // Register write data
   output logic [4:0]           IO_ADDR,        // Low I/O address
   input  wire logic [7:0]      IO_RDATA,       // Low I/O read data
   output logic                 IO_WE,          // I/O write strobe
   output logic [4:0]           IO_WADDR,       // I/O write address
   output logic [7:0]           IO_WDATA,       // I/O write data
   input  wire logic            STATUS_LOAD,    // Load flags from core
   input  wire logic [7:0]      STATUS_LOAD_DATA, // Flags to load
   output logic [7:0]           STATUS_REG      // Status register
);
   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   // Masked opcode compare, used for every pattern
   function automatic logic op_is(input logic [15:0] w,
                                  input logic [15:0] m,
                                  input logic [15:0] p);
      op_is = ((w & m) == p);
   endfunction

   // Words that carry a second address word
   function automatic logic two_words(input logic [15:0] w);
      two_words = op_is(w, M_JMPC, P_JMPC) || op_is(w, M_ONE, P_LDDIR)
                  || op_is(w, M_ONE, P_STDIR);
   endfunction

   typedef enum {ST_EXEC, ST_HOLD} bss_state_t;

   bss_state_t      state_q;
   logic [1:0]      hold_q;
   logic [1:0]      hold_d;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [7:0]      status_q;
   logic [7:0]      status_d;
   logic            flags_we;
   bss_op_t         op;
   logic            accept;
   logic [7:0]      res;
   logic            wr_reg;
   logic            wr_io;
   logic            cond;
   logic            rd_bit;
   logic [PC_W-1:0] disp;
   logic            rf_we_q;
   logic [4:0]      rf_waddr_q;
   logic [7:0]      rf_wdata_q;
   logic            io_we_q;
   logic [4:0]      io_waddr_q;
   logic [7:0]      io_wdata_q;

   assign accept = INSTR_VALID && (state_q == ST_EXEC);
   assign BUSY   = (state_q == ST_HOLD);

   // ------------------------------------------------------------------
   // Instruction class decode
   // ------------------------------------------------------------------
   // SHIFT_LEFT_LOGICAL and ROTATE_LEFT_VIA_CARRY share the add encodings with equal source and target
   always_comb begin
      op = OP_NONE;
      if (op_is(INSTR, M_CPI, P_CPI)) begin
         op = OP_CPI;
      end else if (op_is(INSTR, M_SKR, P_SKRC)
                   || op_is(INSTR, M_SKR, P_SKRS)) begin
         op = OP_SKR;
      end else if (op_is(INSTR, M_IOB, P_SKIOC)
                   || op_is(INSTR, M_IOB, P_SKIOS)) begin
         op = OP_SKIO;
      end else if (op_is(INSTR, M_IOB, P_SETIO)
                   || op_is(INSTR, M_IOB, P_CLRIO)) begin
         op = OP_IOBIT;
      end else if (op_is(INSTR, M_BRF, P_BRFS)
                   || op_is(INSTR, M_BRF, P_BRFC)) begin
         op = OP_BRF;
      end else if (INSTR[8:4] == {INSTR[9], INSTR[3:0]}
                   && op_is(INSTR, M_ADDF, P_LSL)) begin
         op = OP_LSL;
      end else if (INSTR[8:4] == {INSTR[9], INSTR[3:0]}
                   && op_is(INSTR, M_ADDF, P_ROL)) begin
         op = OP_ROL;
      end else if (op_is(INSTR, M_ONE, P_LSR)) begin
         op = OP_LSR;
      end else if (op_is(INSTR, M_ONE, P_ROR)) begin
         op = OP_ROR;
      end else if (op_is(INSTR, M_ONE, P_ASR)) begin
         op = OP_ASR;
      end else if (op_is(INSTR, M_ONE, P_SWAP)) begin
         op = OP_SWAP;
      end
   end

   // Compare uses only the upper half of the register file
   assign RF_RADDR = (op == OP_CPI) ? (HI_REG_BASE | {1'b0, INSTR[7:4]})
                                    : INSTR[8:4];
   // The opcode has only five address bits, so no access leaves 0x00-0x1F
   assign IO_ADDR  = INSTR[7:3] & IO_BIT_TOP;

   // Bit under test for the skip forms
   assign rd_bit = (op == OP_SKIO) ? IO_RDATA[INSTR[2:0]]
                                   : RF_RDATA[INSTR[2:0]];

   // Branch displacement, sign extended to the counter width
   assign disp = PC_W'($signed(INSTR[9:3]));

   // ------------------------------------------------------------------
   // Execute: result, flags, next PC and stall length
   // ------------------------------------------------------------------
   always_comb begin
      res      = 8'h00;
      wr_reg   = 1'b0;
      wr_io    = 1'b0;
      flags_we = 1'b0;
      cond     = 1'b0;
      status_d = status_q;
      pc_d     = pc_q + PC_W'(1);
      hold_d   = 2'h0;
      case (op)
         OP_CPI: begin
            // Difference is formed for flags only, never written back
            res = RF_RDATA - {INSTR[11:8], INSTR[3:0]};
            flags_we = 1'b1;
            status_d[FLAG_H] = (~RF_RDATA[3] & INSTR[3])
                               | (INSTR[3] & res[3])
                               | (res[3] & ~RF_RDATA[3]);
            status_d[FLAG_V] = (RF_RDATA[7] & ~INSTR[11] & ~res[7])
                               | (~RF_RDATA[7] & INSTR[11] & res[7]);
            status_d[FLAG_C] = (~RF_RDATA[7] & INSTR[11])
                               | (INSTR[11] & res[7])
                               | (res[7] & ~RF_RDATA[7]);
            status_d[FLAG_N] = res[7];
            status_d[FLAG_Z] = (res == 8'h00);
            status_d[FLAG_S] = res[7] ^ status_d[FLAG_V];
         end
         OP_SKR, OP_SKIO: begin
            // Bit 9 selects skip on one, else skip on zero
            cond = (rd_bit == INSTR[9]);
            if (cond) begin
               if (two_words(NEXT_INSTR)) begin
                  pc_d   = pc_q + PC_W'(3);
                  hold_d = HOLD_SKIP_TWO;
               end else begin
                  pc_d   = pc_q + PC_W'(2);
                  hold_d = HOLD_SKIP_ONE;
               end
            end
         end
         OP_BRF: begin
            // Named forms are this test with a fixed flag index
            // C: same-or-higher/lower; Z, N, H, T, V, I alike; S=N^V
            cond = (status_q[INSTR[2:0]] == ~INSTR[10]);
            if (INSTR[2:0] == 3'(FLAG_S)) begin
               cond = ((status_q[FLAG_N] ^ status_q[FLAG_V])
                       == ~INSTR[10]);
            end
            if (cond) begin
               pc_d   = pc_q + PC_W'(1) + disp;
               hold_d = HOLD_TAKEN;
            end
         end
         OP_IOBIT: begin
            // Only the addressed bit moves; status bits cleared by a one
            // elsewhere in the register are written back as read
            res = IO_RDATA;
            res[INSTR[2:0]] = INSTR[9];
            wr_io  = 1'b1;
            hold_d = HOLD_IO_RMW;
         end
         OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: begin
            wr_reg   = 1'b1;
            flags_we = 1'b1;
            if (op == OP_LSL) begin
               res = {RF_RDATA[6:0], 1'b0};
               status_d[FLAG_C] = RF_RDATA[7];
            end else if (op == OP_ROL) begin
               res = {RF_RDATA[6:0], status_q[FLAG_C]};
               status_d[FLAG_C] = RF_RDATA[7];
            end else if (op == OP_LSR) begin
               res = {1'b0, RF_RDATA[7:1]};
               status_d[FLAG_C] = RF_RDATA[0];
            end else if (op == OP_ROR) begin
               res = {status_q[FLAG_C], RF_RDATA[7:1]};
               status_d[FLAG_C] = RF_RDATA[0];
            end else begin
               res = {RF_RDATA[7], RF_RDATA[7:1]};
               status_d[FLAG_C] = RF_RDATA[0];
            end
            // Common shift flags: overflow is sign xor carry out
            status_d[FLAG_N] = res[7];
            status_d[FLAG_Z] = (res == 8'h00);
            status_d[FLAG_V] = res[7] ^ status_d[FLAG_C];
            status_d[FLAG_S] = status_d[FLAG_N] ^ status_d[FLAG_V];
         end
         OP_SWAP: begin
            res    = {RF_RDATA[3:0], RF_RDATA[7:4]};
            wr_reg = 1'b1;
         end
         default: begin
            res = 8'h00;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Sequencer: stall cycles after a skip, taken branch or I/O write
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         state_q <= ST_EXEC;
         hold_q  <= 2'h0;
      end else begin
         case (state_q)
            ST_EXEC: begin
               if (accept && hold_d != 2'h0) begin
                  state_q <= ST_HOLD;
                  hold_q  <= hold_d;
               end
            end
            ST_HOLD: begin
               if (hold_q == 2'h1) begin
                  state_q <= ST_EXEC;
               end
               hold_q <= hold_q - 2'h1;
            end
            default: begin
               state_q <= ST_EXEC;
               hold_q  <= 2'h0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Program counter, moved once per accepted instruction
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         pc_q <= '0;
      end else if (accept) begin
         pc_q <= pc_d;
      end
   end

   // ------------------------------------------------------------------
   // Status register: own flag updates win over a core load
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         status_q <= STATUS_RESET;
      end else if (accept && flags_we) begin
         status_q <= status_d;
      end else if (STATUS_LOAD) begin
         status_q <= STATUS_LOAD_DATA;
      end
   end

   // ------------------------------------------------------------------
   // Register file write port, one cycle after execute
   // ------------------------------------------------------------------
   // Registered for timing; the file must forward a pending write
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rf_we_q    <= 1'b0;
         rf_waddr_q <= 5'h00;
         rf_wdata_q <= 8'h00;
      end else begin
         rf_we_q <= accept && wr_reg;
         if (accept && wr_reg) begin
            rf_waddr_q <= INSTR[8:4];
            rf_wdata_q <= res;
         end
      end
   end

   // ------------------------------------------------------------------
   // I/O write port: second cycle of the bit set or clear
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         io_we_q    <= 1'b0;
         io_waddr_q <= 5'h00;
         io_wdata_q <= 8'h00;
      end else begin
         io_we_q <= accept && wr_io;
         if (accept && wr_io) begin
            io_waddr_q <= IO_ADDR;
            io_wdata_q <= res;
         end
      end
   end

   // Outputs
   assign PC         = pc_q;
   assign STATUS_REG = status_q;
   assign RF_WE      = rf_we_q;
   assign RF_WADDR   = rf_waddr_q;
   assign RF_WDATA   = rf_wdata_q;
   assign IO_WE      = io_we_q;
   assign IO_WADDR   = io_waddr_q;
   assign IO_WDATA   = io_wdata_q;
endmodule
`default_nettype wire

// file: rtl/bss_pkg.sv
// Constants and opcode patterns shared by the branch, skip and shift unit
package bss_pkg;
   // -----------------------------------------------------------------
   // Status register bit positions
   // -----------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // -----------------------------------------------------------------
   // Reset values and limits
   // -----------------------------------------------------------------
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [4:0] IO_BIT_TOP   = 5'h1F;
   localparam logic [4:0] HI_REG_BASE  = 5'h10;

   // -----------------------------------------------------------------
   // Cycle counts, expressed as extra stall cycles after the first
   // -----------------------------------------------------------------
   localparam logic [1:0] HOLD_SKIP_ONE = 2'h1;
   localparam logic [1:0] HOLD_SKIP_TWO = 2'h2;
   localparam logic [1:0] HOLD_TAKEN    = 2'h1;
   localparam logic [1:0] HOLD_IO_RMW   = 2'h1;

   // -----------------------------------------------------------------
   // Opcode masks and patterns
   // -----------------------------------------------------------------
   localparam logic [15:0] M_CPI   = 16'hF000;
   localparam logic [15:0] P_CPI   = 16'h3000;
   localparam logic [15:0] M_SKR   = 16'hFE08;
   localparam logic [15:0] P_SKRC  = 16'hFC00;
   localparam logic [15:0] P_SKRS  = 16'hFE00;
   localparam logic [15:0] M_IOB   = 16'hFF00;
   localparam logic [15:0] P_CLRIO = 16'h9800;
   localparam logic [15:0] P_SKIOC = 16'h9900;
   localparam logic [15:0] P_SETIO = 16'h9A00;
   localparam logic [15:0] P_SKIOS = 16'h9B00;
   localparam logic [15:0] M_BRF   = 16'hFC00;
   localparam logic [15:0] P_BRFS  = 16'hF000;
   localparam logic [15:0] P_BRFC  = 16'hF400;
   localparam logic [15:0] M_ADDF  = 16'hFC00;
   localparam logic [15:0] P_LSL   = 16'h0C00;
   localparam logic [15:0] P_ROL   = 16'h1C00;
   localparam logic [15:0] M_ONE   = 16'hFE0F;
   localparam logic [15:0] P_SWAP  = 16'h9402;
   localparam logic [15:0] P_ASR   = 16'h9405;
   localparam logic [15:0] P_LSR   = 16'h9406;
   localparam logic [15:0] P_ROR   = 16'h9407;
   localparam logic [15:0] M_JMPC  = 16'hFE0C;
   localparam logic [15:0] P_JMPC  = 16'h940C;
   localparam logic [15:0] P_LDDIR = 16'h9000;
   localparam logic [15:0] P_STDIR = 16'h9200;

   // Operation selected for the current instruction
   typedef enum logic [3:0] {
      OP_NONE, OP_CPI, OP_SKR, OP_SKIO, OP_BRF, OP_IOBIT,
      OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP
   } bss_op_t;
endpackage

// file: tb/bss_exec_properties.sv
// Concurrent checks on the ports of the execution unit
`timescale 1ns/10ps
`default_nettype none
module bss_exec_properties
   import bss_pkg::*;
#(
   parameter int PC_W = 13 // Program counter width
) (
   input wire logic            REF_CLK,     // Core clock
   input wire logic            RESET,       // Async reset
   input wire logic            INSTR_VALID, // Word present
   input wire logic [15:0]     INSTR,       // Current word
   input wire logic [15:0]     NEXT_INSTR,  // Following word
   input wire logic            BUSY,        // Stall
   input wire logic [PC_W-1:0] PC,          // Program counter
   input wire logic [7:0]      RF_RDATA,    // Register data
   input wire logic            RF_WE,       // Register write
   input wire logic [7:0]      RF_WDATA,    // Register write data
   input wire logic [7:0]      IO_RDATA,    // I/O data
   input wire logic            IO_WE,       // I/O write
   input wire logic            STATUS_LOAD, // Flag load
   input wire logic [7:0]      STATUS_REG   // Flags
);
   // ----
   // Decode helpers
   // ----
   logic            acc, is_brf, is_skip, is_io, flag, taken, hit, two;
   logic [PC_W-1:0] target;
   assign acc     = INSTR_VALID && !BUSY;
   assign is_brf  = (INSTR & M_BRF) == P_BRFS || (INSTR & M_BRF) == P_BRFC;
   assign is_io   = (INSTR & M_IOB) == P_SETIO || (INSTR & M_IOB) == P_CLRIO;
   assign is_skip = (INSTR & M_SKR) == P_SKRC || (INSTR & M_SKR) == P_SKRS
                 || (INSTR & M_IOB) == P_SKIOC || (INSTR & M_IOB) == P_SKIOS;
   // S position tests N xor V directly
   assign flag  = (INSTR[2:0] == 3'h4) ? STATUS_REG[FLAG_N] ^ STATUS_REG[FLAG_V]
                                       : STATUS_REG[INSTR[2:0]];
   assign taken = INSTR[10] ? !flag : flag;
   assign target = PC + PC_W'(1) + {{(PC_W-7){INSTR[9]}}, INSTR[9:3]};
   // Bit 9 picks the skip-if-set variant in both skip families
   assign hit = (INSTR[15:12] == 4'hF ? RF_RDATA[INSTR[2:0]]
                                      : IO_RDATA[INSTR[2:0]]) == INSTR[9];
   assign two = (NEXT_INSTR & M_JMPC) == P_JMPC
             || (NEXT_INSTR & M_ONE) == P_LDDIR
             || (NEXT_INSTR & M_ONE) == P_STDIR;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);

   sequence s_one_stall;
      BUSY ##1 !BUSY;
   endsequence
   sequence s_two_stall;
      BUSY[*2] ##1 !BUSY;
   endsequence

   a_cpi_no_write: assert property (acc && (INSTR & M_CPI) == P_CPI
      |=> !RF_WE && !BUSY) else $error("compare wrote or stalled");
   a_skip_one_word: assert property (acc && is_skip && hit && !two
      |=> PC == PC_W'($past(PC) + 2) ##0 s_one_stall)
      else $error("one-word skip wrong");
   a_skip_two_word: assert property (acc && is_skip && hit && two
      |=> PC == PC_W'($past(PC) + 3) ##0 s_two_stall)
      else $error("two-word skip wrong");
   a_skip_miss_next: assert property (acc && is_skip && !hit
      |=> PC == PC_W'($past(PC) + 1) && !BUSY) else $error("skip miss wrong");
   a_branch_taken: assert property (acc && is_brf && taken
      |=> PC == $past(target) ##0 s_one_stall) else $error("branch target");
   a_branch_untaken: assert property (acc && is_brf && !taken
      |=> PC == PC_W'($past(PC) + 1) && !BUSY) else $error("branch fell wrong");
   a_io_rmw_steps: assert property (acc && is_io
      |=> IO_WE ##0 s_one_stall ##0 !IO_WE) else $error("I/O bit op steps");
   a_flags_untouched: assert property (acc && (is_skip || is_brf || is_io
      || (INSTR & M_ONE) == P_SWAP) && !STATUS_LOAD |=> $stable(STATUS_REG))
      else $error("flags changed");
   a_lsr_result: assert property (acc && (INSTR & M_ONE) == P_LSR
      |=> RF_WE && RF_WDATA == ($past(RF_RDATA) >> 1) && !STATUS_REG[FLAG_N])
      else $error("right shift result");
   a_busy_pc_hold: assert property (BUSY |=> $stable(PC))
      else $error("PC moved in stall");
endmodule

bind bss_exec bss_exec_properties #(.PC_W(PC_W)) bss_exec_properties_i (
   .REF_CLK(REF_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
   .INSTR(INSTR), .NEXT_INSTR(NEXT_INSTR), .BUSY(BUSY), .PC(PC),
   .RF_RDATA(RF_RDATA), .RF_WE(RF_WE), .RF_WDATA(RF_WDATA),
   .IO_RDATA(IO_RDATA), .IO_WE(IO_WE), .STATUS_LOAD(STATUS_LOAD),
   .STATUS_REG(STATUS_REG));
`default_nettype wire

// file: tb/bss_far_model.sv
// Behavioural register file and low I/O space beside the execution unit
`timescale 1ns/10ps
`default_nettype none
module bss_far_model (
   input  wire logic       REF_CLK,  // Core clock
   input  wire logic [4:0] RF_RADDR, // Register read address
   output logic [7:0]      RF_RDATA, // Register read data
   input  wire logic       RF_WE,    // Register write strobe
   input  wire logic [4:0] RF_WADDR, // Register write address
   input  wire logic [7:0] RF_WDATA, // Register write data
   input  wire logic [4:0] IO_ADDR,  // I/O read address
   output logic [7:0]      IO_RDATA, // I/O read data
   input  wire logic       IO_WE,    // I/O write strobe
   input  wire logic [4:0] IO_WADDR, // I/O write address
   input  wire logic [7:0] IO_WDATA  // I/O write data
);
   // ----
   // Storage and read paths
   // ----
   logic [7:0] regs [32];
   logic [7:0] io   [32];
   // Forward writes in flight, since the unit writes one cycle late
   assign RF_RDATA = (RF_WE && RF_WADDR == RF_RADDR) ? RF_WDATA
                                                     : regs[RF_RADDR];
   assign IO_RDATA = (IO_WE && IO_WADDR == IO_ADDR) ? IO_WDATA
                                                    : io[IO_ADDR];
   // Plain always, so the bench may preload cells directly
   always @(posedge REF_CLK) begin
      if (RF_WE) regs[RF_WADDR] <= RF_WDATA;
      if (IO_WE) io[IO_WADDR] <= IO_WDATA; // Only 32 cells
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the branch, skip and shift unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bss_pkg::*;
   localparam int PC_W = 13;
   logic            REF_CLK, RESET, INSTR_VALID, STATUS_LOAD;
   logic            BUSY, RF_WE, IO_WE, c1_rf, c1_io;
   logic [15:0]     INSTR, NEXT_INSTR;
   logic [7:0]      STATUS_LOAD_DATA, STATUS_REG, RF_RDATA, RF_WDATA;
   logic [7:0]      IO_RDATA, IO_WDATA, c1_wd;
   logic [4:0]      RF_RADDR, RF_WADDR, IO_ADDR, IO_WADDR;
   logic [PC_W-1:0] PC, pc0;
   int              failures, tests_run, n_cyc;

   bss_exec #(.PC_W(PC_W)) bss_exec_i (.REF_CLK(REF_CLK), .RESET(RESET),
      .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .NEXT_INSTR(NEXT_INSTR),
      .BUSY(BUSY), .PC(PC), .RF_RADDR(RF_RADDR), .RF_RDATA(RF_RDATA),
      .RF_WE(RF_WE), .RF_WADDR(RF_WADDR), .RF_WDATA(RF_WDATA),
      .IO_ADDR(IO_ADDR), .IO_RDATA(IO_RDATA), .IO_WE(IO_WE),
      .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA), .STATUS_LOAD(STATUS_LOAD),
      .STATUS_LOAD_DATA(STATUS_LOAD_DATA), .STATUS_REG(STATUS_REG));
   bss_far_model bss_far_model_i (.REF_CLK(REF_CLK), .RF_RADDR(RF_RADDR),
      .RF_RDATA(RF_RDATA), .RF_WE(RF_WE), .RF_WADDR(RF_WADDR),
      .RF_WDATA(RF_WDATA), .IO_ADDR(IO_ADDR), .IO_RDATA(IO_RDATA),
      .IO_WE(IO_WE), .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA));

   // ----
   // Shared tasks
   // ----
   task automatic check(input string what, input logic [15:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One instruction; notes what shows in the cycle after acceptance
   task automatic issue(input logic [15:0] ins, nxt);
      @(posedge REF_CLK);
      INSTR <= ins;
      NEXT_INSTR <= nxt;
      INSTR_VALID <= 1'b1;
      pc0 = PC;
      @(posedge REF_CLK);
      INSTR_VALID <= 1'b0;
      #1;
      c1_rf = RF_WE;
      c1_io = IO_WE;
      c1_wd = RF_WDATA;
      n_cyc = 1;
      // Bounded, so a stuck stall cannot hang the run
      for (int i = 0; i < 8 && BUSY !== 1'b0; i++) begin
         @(posedge REF_CLK);
         #1;
         n_cyc++;
      end
   endtask
   task automatic load_flags(input logic [7:0] v);
      @(posedge REF_CLK);
      STATUS_LOAD <= 1'b1;
      STATUS_LOAD_DATA <= v;
      @(posedge REF_CLK);
      STATUS_LOAD <= 1'b0;
      #1;
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_compare();
      logic [15:0] ins [4] = '{16'h3200, 16'h3100, 16'h3001, 16'h3001};
      logic [7:0]  val [4] = '{8'h10, 8'h10, 8'h10, 8'h80};
      logic [7:0]  flg [4] = '{8'h15, 8'h02, 8'h20, 8'h38};
      for (int i = 0; i < 4; i++) begin
         bss_far_model_i.regs[16] = val[i];
         issue(ins[i], 16'h0000);
         check("compare flags", {8'h00, flg[i]}, {8'h00, STATUS_REG});
         check("compare write", 16'h0000, {15'h0, c1_rf});
         check("compare cycles", 16'h0001, 16'(n_cyc));
      end
      $display("t_compare done");
   endtask
   task automatic t_shifts();
      logic [15:0] ins [6] = '{16'h0C11, 16'h9416, 16'h1C11, 16'h9417,
                               16'h9415, 16'h9412};
      logic [7:0] x = 8'h80;
      logic [7:0] r, st;
      logic       c;
      for (int i = 0; i < 6; i++) begin
         load_flags(8'h41);
         bss_far_model_i.regs[1] = x;
         issue(ins[i], 16'h0000);
         case (i)
            0: {c, r} = {x, 1'b0};
            1: {r, c} = {1'b0, x};
            2: {c, r} = {x, 1'b1};
            3: {r, c} = {1'b1, x};
            4: {r, c} = {x[7], x};
            default: {c, r} = {1'b0, x[3:0], x[7:4]};
         endcase
         st = (i == 5) ? 8'h41 : {3'b010, c, r[7] ^ c, r[7], r == 8'h00, c};
         check("shift data", {8'h00, r}, {8'h00, c1_wd});
         check("shift flags", {8'h00, st}, {8'h00, STATUS_REG});
         check("shift cycles", 16'h0001, 16'(n_cyc));
      end
      $display("t_shifts done");
   endtask
   task automatic t_skips();
      logic [15:0] pat [4] = '{P_SKRC | 16'h0020, P_SKRS | 16'h0020,
                               P_SKIOC | 16'h0018, P_SKIOS | 16'h0018};
      logic [7:0]  st;
      int          e;
      bss_far_model_i.regs[2] = 8'h80;
      bss_far_model_i.io[3] = 8'h80;
      for (int k = 0; k < 16; k++) begin
         st = STATUS_REG;
         issue(pat[k / 4] | (k[1] ? 16'h0007 : 16'h0000),
               k[0] ? P_JMPC : 16'h0000);
         e = (k[1] == k[2]) ? (k[0] ? 3 : 2) : 1;
         check("skip pc step", 16'(e), 16'(PC - pc0));
         check("skip cycles", 16'(e), 16'(n_cyc));
         check("skip flags", {8'h00, st}, {8'h00, STATUS_REG});
      end
      $display("t_skips done");
   endtask
   task automatic t_branches();
      logic [7:0]      pats [3] = '{8'hA1, 8'h5E, 8'h5A};
      logic [6:0]      k;
      logic            f, tk;
      logic [PC_W-1:0] e;
      for (int p = 0; p < 3; p++) begin
         load_flags(pats[p]);
         for (int j = 0; j < 16; j++) begin
            k = j[0] ? 7'h05 : 7'h7D;
            f = (j[2:0] == 3'h4) ? pats[p][2] ^ pats[p][3] : pats[p][j[2:0]];
            tk = j[3] ? !f : f;
            issue((j[3] ? P_BRFC : P_BRFS) | {6'h00, k, j[2:0]}, 16'h0000);
            e = pc0 + PC_W'(1) + (tk ? {{(PC_W-7){k[6]}}, k} : PC_W'(0));
            check("branch pc", 16'(e), 16'(PC));
            check("branch cycles", tk ? 16'h0002 : 16'h0001, 16'(n_cyc));
         end
      end
      $display("t_branches done");
   endtask
   task automatic t_io_bits();
      bss_far_model_i.io[31] = 8'hF0;
      issue(P_SETIO | 16'h00FA, 16'h0000);
      check("set bit", 16'h00F4, {8'h00, bss_far_model_i.io[31]});
      check("set cycles", 16'h0002, 16'(n_cyc));
      issue(P_CLRIO | 16'h00FF, 16'h0000);
      check("clear bit", 16'h0074, {8'h00, bss_far_model_i.io[31]});
      check("clear pulse", 16'h0001, {15'h0, c1_io});
      $display("t_io_bits done");
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end
   // Hang guard: the whole sequence needs about 220 cycles
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   initial begin
      {RESET, INSTR_VALID, STATUS_LOAD} = 3'b100;
      {INSTR, NEXT_INSTR, STATUS_LOAD_DATA} = '0;
      failures = 0;
      tests_run = 0;
      repeat (12) @(posedge REF_CLK);
      RESET <= 1'b0;
      #1;
      check("reset pc", 16'h0000, 16'(PC));
      check("reset flags", 16'h0000, {8'h00, STATUS_REG});
      t_compare();
      t_shifts();
      t_skips();
      t_branches();
      t_io_bits();
      wrap_up();
   end
endmodule
`default_nettype wire
